// File: ppd_defs.svh
// Constants of the point-plot display enable/status block
`ifndef PPD_DEFS_SVH
`define PPD_DEFS_SVH

// ----------------------------------------------------------------
// Clock and intervals, each in its own unit
// ----------------------------------------------------------------
`define PPD_CLK_MHZ    250
`define PPD_ERASE_MS   450
`define PPD_R2G_US     1600
`define PPD_G2R_US     300
`define PPD_SETTLE_US  21
`define PPD_INTENS_US  1
`define PPD_MS_TO_US   1000
`define PPD_TMR_W      27

// ----------------------------------------------------------------
// Device command codes (low three bits of the I/O instruction)
// ----------------------------------------------------------------
`define PPD_OP_CLEAR_ALL   3'h0
`define PPD_OP_CLEAR_DONE  3'h1
`define PPD_OP_SKIP_DONE   3'h2
`define PPD_OP_LOAD_X      3'h3
`define PPD_OP_LOAD_Y      3'h4
`define PPD_OP_INTENSIFY   3'h5
`define PPD_OP_LOAD_EN     3'h6
`define PPD_OP_READ_EN     3'h7

// ----------------------------------------------------------------
// Word layout: word bit 0 is the most significant accumulator bit
// ----------------------------------------------------------------
`define PPD_WORD_W   12
`define PPD_COORD_W  10
`define PPD_B_DONE   11
`define PPD_B_WT     5
`define PPD_B_STORE  4
`define PPD_B_ERASE  3
`define PPD_B_COLOR  2
`define PPD_B_CHAN   1
`define PPD_B_IE     0
`define PPD_WORD_ZERO 12'h000

`endif

// File: ppd_display_ctl.sv
// Point-plot display control: enable/status word and done sequencing
//
// How it works
// - Done flag reads back in word bit 0
// - Load-enable does not set done itself; an erase or colour change it starts sets done at expiry
// - Write-through plus intensify draws unstored locating ellipse
// - Store bit selects store or non-store mode
// - Erase bit starts a 450 ms erase
// - Erase holds done clear, blocks display operations
// - Erase bit reads back as zero
// - Colour change sets done after switch interval
// - Channel bit picks first or second channel
// - Interrupt requested while enabled and done
// - Channel and interrupt enable written and read
// - Load-enable copies accumulator, then clears it
// - Read-enable returns the word to accumulator
// - Load X/Y: clear done, load, settle, done
// - Intensify: clear done, pulse beam, done
`timescale 1ns/1ps
`include "ppd_defs.svh"
module ppd_display_ctl #(
  parameter int ERASE_CYC  = `PPD_ERASE_MS * `PPD_MS_TO_US * `PPD_CLK_MHZ,
  parameter int R2G_CYC    = `PPD_R2G_US * `PPD_CLK_MHZ,
  parameter int G2R_CYC    = `PPD_G2R_US * `PPD_CLK_MHZ,
  parameter int SETTLE_CYC = `PPD_SETTLE_US * `PPD_CLK_MHZ
) (
  // Clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  // Processor I/O instruction
  input  wire logic                     iot_valid,
  input  wire logic [2:0]               iot_code,
  input  wire logic [`PPD_WORD_W-1:0]   ac_in,
  // Processor answer
  output logic                          ac_valid,
  output logic [`PPD_WORD_W-1:0]        ac_out,
  output logic                          skip,
  output logic                          irq,
  // Oscilloscope side
  output logic [`PPD_COORD_W-1:0]       x_out,
  output logic [`PPD_COORD_W-1:0]       y_out,
  output logic                          beam_on,
  output logic                          locate_ellipse,
  output logic                          store_mode,
  output logic                          erase_out,
  output logic                          red_mode,
  output logic                          chan_sel
);

  localparam int INTENS_CYC = `PPD_INTENS_US * `PPD_CLK_MHZ;

  ppd_pkg::ppd_state_s st_reg;
  ppd_pkg::ppd_state_s st_next;
  logic                  tmr_start;
  logic                  tmr_abort;
  logic [`PPD_TMR_W-1:0] tmr_count;
  logic                  erasing;
  logic                  cmd;
  logic [`PPD_WORD_W-1:0] status_word;

  ppd_tmr_if tif ();

  // ----------------------------------------------------------------
  // Interval timer
  // ----------------------------------------------------------------
  ppd_timer u_timer (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .tif     (tif)
  );

  // Timer controls
  assign tif.start = tmr_start;
  assign tif.abort = tmr_abort;
  assign tif.count = tmr_count;

  // Decode helpers
  assign erasing = (st_reg.op == ppd_pkg::PPD_ERASE);
  assign cmd     = iot_valid;

  // Read-back word, erase bit always zero
  always_comb begin
    status_word                = `PPD_WORD_ZERO;
    status_word[`PPD_B_DONE]   = st_reg.done;
    status_word[`PPD_B_WT]     = st_reg.wt;
    status_word[`PPD_B_STORE]  = st_reg.store;
    status_word[`PPD_B_ERASE]  = 1'b0;
    status_word[`PPD_B_COLOR]  = st_reg.red;
    status_word[`PPD_B_CHAN]   = st_reg.chan;
    status_word[`PPD_B_IE]     = st_reg.ie;
  end

  // ----------------------------------------------------------------
  // Command decode and done sequencing
  // ----------------------------------------------------------------
  always_comb begin
    st_next          = st_reg;
    st_next.ac_valid = 1'b0;
    st_next.skip     = 1'b0;
    tmr_start        = 1'b0;
    tmr_abort        = 1'b0;
    tmr_count        = '0;
    // Timed operation finished: done set, wins over a clear
    if (tif.expired) begin
      st_next.done      = 1'b1;
      st_next.beam_on   = 1'b0;
      st_next.ellipse   = 1'b0;
      st_next.erase_out = 1'b0;
      st_next.op        = ppd_pkg::PPD_IDLE;
    end
    if (cmd) begin
      case (iot_code)
        `PPD_OP_CLEAR_ALL: begin
          st_next      = '0;
          st_next.x    = st_reg.x;
          st_next.y    = st_reg.y;
          st_next.done = tif.expired;           // Same-cycle expiry still sets done
          tmr_abort    = 1'b1;
        end
        `PPD_OP_CLEAR_DONE: begin
          if (!tif.expired) begin
            st_next.done = 1'b0;
          end
        end
        `PPD_OP_SKIP_DONE: begin
          st_next.skip = st_reg.done;
        end
        `PPD_OP_LOAD_X, `PPD_OP_LOAD_Y: begin
          if (!erasing) begin
            if (iot_code == `PPD_OP_LOAD_X) begin
              st_next.x = ac_in[`PPD_COORD_W-1:0];
            end else begin
              st_next.y = ac_in[`PPD_COORD_W-1:0];
            end
            st_next.done = 1'b0;
            st_next.op   = ppd_pkg::PPD_SETTLE;
            tmr_start    = 1'b1;
            tmr_count    = `PPD_TMR_W'(SETTLE_CYC);
          end
        end
        `PPD_OP_INTENSIFY: begin
          if (!erasing) begin
            st_next.done    = 1'b0;
            st_next.beam_on = !st_reg.wt;
            st_next.ellipse = st_reg.wt;
            st_next.op      = ppd_pkg::PPD_INTENS;
            tmr_start       = 1'b1;
            tmr_count       = `PPD_TMR_W'(INTENS_CYC);
          end
        end
        `PPD_OP_LOAD_EN: begin
          // Done bit of the accumulator is ignored
          st_next.wt       = ac_in[`PPD_B_WT];
          st_next.store    = ac_in[`PPD_B_STORE];
          st_next.chan     = ac_in[`PPD_B_CHAN];
          st_next.ie       = ac_in[`PPD_B_IE];
          st_next.red      = ac_in[`PPD_B_COLOR];
          st_next.ac_valid = 1'b1;
          st_next.ac_out   = `PPD_WORD_ZERO;
          if (ac_in[`PPD_B_ERASE]) begin
            st_next.erase_out = 1'b1;
            st_next.done      = 1'b0;
            st_next.beam_on   = 1'b0;
            st_next.ellipse   = 1'b0;
            st_next.op        = ppd_pkg::PPD_ERASE;
            tmr_start         = 1'b1;
            tmr_count         = `PPD_TMR_W'(ERASE_CYC);
          end else if (!erasing && (ac_in[`PPD_B_COLOR] != st_reg.red)) begin
            st_next.done = 1'b0;
            st_next.op   = ppd_pkg::PPD_COLOR;
            tmr_start    = 1'b1;
            tmr_count    = st_reg.red ? `PPD_TMR_W'(R2G_CYC) : `PPD_TMR_W'(G2R_CYC);
          end
        end
        `PPD_OP_READ_EN: begin
          st_next.ac_valid = 1'b1;
          st_next.ac_out   = status_word;
        end
        default: begin
          st_next.skip = 1'b0;
        end
      endcase
    end
    // Interrupt request as a level
    st_next.irq = st_next.ie && st_next.done;
  end

  // State register, cleared at reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign ac_valid       = st_reg.ac_valid;
  assign ac_out         = st_reg.ac_out;
  assign skip           = st_reg.skip;
  assign irq            = st_reg.irq;
  assign x_out          = st_reg.x;
  assign y_out          = st_reg.y;
  assign beam_on        = st_reg.beam_on;
  assign locate_ellipse = st_reg.ellipse;
  assign store_mode     = st_reg.store;
  assign erase_out      = st_reg.erase_out;
  assign red_mode       = st_reg.red;
  assign chan_sel       = st_reg.chan;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_load_en;
    cmd && iot_code == `PPD_OP_LOAD_EN;
  endsequence
  sequence s_read_en;
    cmd && iot_code == `PPD_OP_READ_EN;
  endsequence
  sequence s_color_swap;
    s_load_en ##0 (!ac_in[`PPD_B_ERASE] && !erasing && ac_in[`PPD_B_COLOR] != st_reg.red);
  endsequence

  a_read_done_bit: assert property (s_read_en |=> ac_valid && ac_out[`PPD_B_DONE] == $past(st_reg.done))
    else $error("done bit not returned");
  a_load_no_set: assert property (s_load_en ##0 (!st_reg.done && !tif.expired) |=> !irq && !st_reg.done)
    else $error("load-enable set done");
  a_wt_ellipse: assert property (cmd && iot_code == `PPD_OP_INTENSIFY && !erasing && st_reg.wt
                                  |=> locate_ellipse && !beam_on)
    else $error("write-through ellipse missing");
  a_store_follows: assert property (s_load_en |=> store_mode == $past(ac_in[`PPD_B_STORE]))
    else $error("store mode wrong");
  a_erase_start: assert property (s_load_en ##0 ac_in[`PPD_B_ERASE] |=> (erase_out && !st_reg.done) [*8])
    else $error("erase did not start");
  a_erase_blocks: assert property (erasing && cmd && iot_code == `PPD_OP_LOAD_X |=> x_out == $past(x_out))
    else $error("display op during erase");
  a_erase_hidden: assert property (s_read_en |=> !ac_out[`PPD_B_ERASE])
    else $error("erase bit read back");
  a_color_swap: assert property (s_color_swap |=> red_mode == $past(ac_in[`PPD_B_COLOR]) && !st_reg.done)
    else $error("colour change wrong");
  a_chan_rw: assert property (s_load_en ##1 (!cmd) [*2] ##1 s_read_en
                               |=> ac_out[`PPD_B_CHAN] == $past(ac_in[`PPD_B_CHAN], 4)
                                   && ac_out[`PPD_B_IE] == $past(ac_in[`PPD_B_IE], 4)
                                   && ac_out[`PPD_B_CHAN] == chan_sel)
    else $error("channel bit mismatch");
  a_irq_level: assert property (irq == (st_reg.ie && st_reg.done))
    else $error("interrupt level wrong");
  a_load_clears_ac: assert property (s_load_en |=> ac_valid && ac_out == `PPD_WORD_ZERO)
    else $error("accumulator not cleared");
  a_intens_pulse: assert property (cmd && iot_code == `PPD_OP_INTENSIFY && !erasing && !st_reg.wt
                                    |=> beam_on && !st_reg.done)
    else $error("intensify did not pulse");

endmodule // ppd_display_ctl

// File: ppd_pkg.sv
// Types shared by the point-plot display modules
`include "ppd_defs.svh"
package ppd_pkg;

  // Operation that owns the interval timer
  typedef enum logic [2:0] {
    PPD_IDLE,
    PPD_SETTLE,
    PPD_INTENS,
    PPD_ERASE,
    PPD_COLOR
  } ppd_op_e;

  // Whole state of the control module
  typedef struct packed {
    ppd_op_e                   op;
    logic                      done;
    logic                      wt;
    logic                      store;
    logic                      red;
    logic                      chan;
    logic                      ie;
    logic [`PPD_COORD_W-1:0]   x;
    logic [`PPD_COORD_W-1:0]   y;
    logic                      beam_on;
    logic                      ellipse;
    logic                      erase_out;
    logic                      ac_valid;
    logic [`PPD_WORD_W-1:0]    ac_out;
    logic                      skip;
    logic                      irq;
  } ppd_state_s;

  // Whole state of the interval timer
  typedef struct packed {
    logic                      busy;
    logic [`PPD_TMR_W-1:0]     cnt;
    logic                      expired;
  } ppd_tmr_s;

endpackage

// File: ppd_scope_model.sv
// Oscilloscope stand-in: counts dots, locating ellipses and erase length
`timescale 1ns/1ps
`include "ppd_defs.svh"
module ppd_scope_model (
  // Clock and reset
  input  wire logic                    sys_clk,
  input  wire logic                    arst_n,
  // Deflection and intensity inputs
  input  wire logic [`PPD_COORD_W-1:0] x_in,
  input  wire logic                    beam_in,
  input  wire logic                    ellipse_in,
  input  wire logic                    erase_in,
  // Observations for the bench
  output int                           dots,
  output int                           ellipses,
  output int                           erase_len,
  output logic [`PPD_COORD_W-1:0]      dot_x
);
  int   erase_cnt;
  logic beam_q;
  logic ell_q;

  // Rising beam or ellipse marks one event; erase length latched at its fall
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      dots      <= 0;
      ellipses  <= 0;
      erase_len <= 0;
      erase_cnt <= 0;
      dot_x     <= '0;
      beam_q    <= 1'b0;
      ell_q     <= 1'b0;
    end else begin
      beam_q <= beam_in;
      ell_q  <= ellipse_in;
      if (beam_in && !beam_q) begin
        dots  <= dots + 1;
        dot_x <= x_in;
      end
      if (ellipse_in && !ell_q) ellipses <= ellipses + 1;
      if (erase_in) erase_cnt <= erase_cnt + 1;
      else if (erase_cnt != 0) begin
        erase_len <= erase_cnt;
        erase_cnt <= 0;
      end
    end
  end
endmodule // ppd_scope_model

// File: ppd_timer.sv
// Interval timer: counts a loaded number of cycles, pulses on expiry
`timescale 1ns/1ps
`include "ppd_defs.svh"
module ppd_timer (
  // Clock and reset
  input  wire logic  sys_clk,
  input  wire logic  arst_n,
  // Control link
  ppd_tmr_if.tmr     tif
);

  ppd_pkg::ppd_tmr_s tmr_reg;
  ppd_pkg::ppd_tmr_s tmr_next;

  // Next state: load, abort or count down
  always_comb begin
    tmr_next         = tmr_reg;
    tmr_next.expired = 1'b0;
    if (tif.start) begin
      tmr_next.busy = 1'b1;
      tmr_next.cnt  = tif.count;
    end else if (tif.abort) begin
      tmr_next.busy = 1'b0;
    end else if (tmr_reg.busy) begin
      if (tmr_reg.cnt <= `PPD_TMR_W'(1)) begin
        tmr_next.busy    = 1'b0;
        tmr_next.expired = 1'b1;
      end else begin
        tmr_next.cnt = tmr_reg.cnt - `PPD_TMR_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tmr_reg <= '0;
    end else begin
      tmr_reg <= tmr_next;
    end
  end

  assign tif.expired = tmr_reg.expired;

endmodule // ppd_timer

// File: ppd_tmr_if.sv
// Link between the display control and its interval timer
`timescale 1ns/1ps
`include "ppd_defs.svh"
interface ppd_tmr_if;
  logic                   start;
  logic                   abort;
  logic [`PPD_TMR_W-1:0]  count;
  logic                   expired;
  modport ctl (output start, output abort, output count, input expired);
  modport tmr (input start, input abort, input count, output expired);
endinterface

// File: testbench.sv
// Self-checking bench for the point-plot display control
`timescale 1ns/1ps
`include "ppd_defs.svh"
module testbench;
  logic                    sys_clk;
  logic                    arst_n;
  logic                    iot_valid;
  logic [2:0]              iot_code;
  logic [`PPD_WORD_W-1:0]  ac_in;
  logic                    ac_valid;
  logic [`PPD_WORD_W-1:0]  ac_out;
  logic                    skip;
  logic                    irq;
  logic [`PPD_COORD_W-1:0] x_out;
  logic [`PPD_COORD_W-1:0] y_out;
  logic                    beam_on;
  logic                    locate_ellipse;
  logic                    store_mode;
  logic                    erase_out;
  logic                    red_mode;
  logic                    chan_sel;
  logic                    av;
  logic                    sk;
  logic [`PPD_WORD_W-1:0]  ao;
  logic [`PPD_COORD_W-1:0] dot_x;
  int                      dots;
  int                      ellipses;
  int                      erase_len;
  int                      n_wait;
  int                      n_mismatch = 0;
  int                      checks_done = 0;

  // ----------------------------------------------------------------
  // Design, scope model and clock
  // ----------------------------------------------------------------
  ppd_display_ctl #(.ERASE_CYC(200), .R2G_CYC(40), .G2R_CYC(20), .SETTLE_CYC(30)) dut (
    .sys_clk(sys_clk), .arst_n(arst_n), .iot_valid(iot_valid), .iot_code(iot_code),
    .ac_in(ac_in), .ac_valid(ac_valid), .ac_out(ac_out), .skip(skip), .irq(irq),
    .x_out(x_out), .y_out(y_out), .beam_on(beam_on), .locate_ellipse(locate_ellipse),
    .store_mode(store_mode), .erase_out(erase_out), .red_mode(red_mode), .chan_sel(chan_sel));
  ppd_scope_model scope (
    .sys_clk(sys_clk), .arst_n(arst_n), .x_in(x_out), .beam_in(beam_on),
    .ellipse_in(locate_ellipse), .erase_in(erase_out), .dots(dots),
    .ellipses(ellipses), .erase_len(erase_len), .dot_x(dot_x));

  // 250 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // One instruction; one-cycle answer captured just after the accepting edge
  task automatic cmd(input logic [2:0] code, input logic [11:0] val);
    @(posedge sys_clk);
    #1 iot_valid = 1'b1;
    iot_code = code;
    ac_in = val;
    @(posedge sys_clk);
    #1 iot_valid = 1'b0;
    av = ac_valid;
    ao = ac_out;
    sk = skip;
    @(posedge sys_clk);
    #1;
  endtask

  // Wait for done through the interrupt line, bounded
  task automatic wait_irq(input int max_cyc);
    n_wait = 0;
    while (irq !== 1'b1 && n_wait < max_cyc) begin
      @(posedge sys_clk);
      #1 n_wait++;
    end
  endtask

  task automatic in_range(input int lo, input int hi);
    chk(32'(n_wait >= lo && n_wait <= hi), 32'h0000_0001);
  endtask

  task automatic stop_test();
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    stop_test();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    iot_valid = 1'b0;
    iot_code = 3'h0;
    ac_in = 12'h000;
    repeat (10) @(posedge sys_clk);
    #1 arst_n = 1'b1;
    chk(irq, 1'b0);
    cmd(`PPD_OP_READ_EN, 12'h000); chk(ao, 12'h000);
    // Done bit written as 1 is ignored; accumulator cleared
    cmd(`PPD_OP_LOAD_EN, 12'h813); chk({av, ao}, 13'h1000);
    cmd(`PPD_OP_READ_EN, 12'h000); chk({av, ao}, 13'h1013);
    chk({store_mode, chan_sel, irq}, 3'h6);
    // Coordinates: accumulator kept, done cleared then set after settle
    cmd(`PPD_OP_LOAD_X, 12'hABC); chk({av, x_out, irq}, 12'h578);
    wait_irq(100); in_range(27, 33);
    cmd(`PPD_OP_LOAD_Y, 12'h155); chk({av, y_out, irq}, 12'h2AA);
    wait_irq(100); in_range(27, 33);
    cmd(`PPD_OP_READ_EN, 12'h000); chk(ao, 12'h813);
    cmd(`PPD_OP_SKIP_DONE, 12'h000); chk(sk, 1'b1);
    // Plain intensify
    cmd(`PPD_OP_INTENSIFY, 12'h000); chk(irq, 1'b0);
    wait_irq(300); in_range(245, 255);
    chk({dots[7:0], dot_x}, 18'h0_06BC);
    // Write-through intensify draws only the locating ellipse
    cmd(`PPD_OP_LOAD_EN, 12'h021); chk({store_mode, chan_sel}, 2'h0);
    cmd(`PPD_OP_INTENSIFY, 12'h000);
    wait_irq(300); in_range(245, 255);
    chk({dots[7:0], ellipses[7:0]}, 16'h0101);
    // Colour switch intervals in both directions
    cmd(`PPD_OP_LOAD_EN, 12'h005); chk({red_mode, irq}, 2'h2);
    wait_irq(100); in_range(17, 23);
    cmd(`PPD_OP_LOAD_EN, 12'h001); chk({red_mode, irq}, 2'h0);
    wait_irq(100); in_range(37, 43);
    // Interrupt disabled while done; then clear done
    cmd(`PPD_OP_LOAD_EN, 12'h000); chk(irq, 1'b0);
    cmd(`PPD_OP_SKIP_DONE, 12'h000); chk(sk, 1'b1);
    cmd(`PPD_OP_CLEAR_DONE, 12'h000);
    cmd(`PPD_OP_SKIP_DONE, 12'h000); chk(sk, 1'b0);
    // Erase: bit not read back, display operations refused
    cmd(`PPD_OP_LOAD_EN, 12'h009); chk(erase_out, 1'b1);
    cmd(`PPD_OP_READ_EN, 12'h000); chk(ao, 12'h001);
    cmd(`PPD_OP_LOAD_X, 12'h111); chk(x_out, 10'h2BC);
    cmd(`PPD_OP_INTENSIFY, 12'h000);
    wait_irq(300); in_range(180, 200);
    chk({erase_out, dots[7:0]}, 9'h001);
    // Scope model latches the erase length one edge after the fall
    @(posedge sys_clk);
    #1 chk(32'(erase_len >= 197 && erase_len <= 203), 32'h0000_0001);
    // Clear all drops enables, done and interrupt
    cmd(`PPD_OP_CLEAR_ALL, 12'h000); chk(irq, 1'b0);
    cmd(`PPD_OP_READ_EN, 12'h000); chk(ao, 12'h000);
    stop_test();
  end
endmodule // testbench
